// ==== verification/sbsc_ctrl_model.sv ====
// Memory controller model: one command on the pins per clock cycle.
// Assumes the bench calls issue() once for every cycle it fills.
`timescale 1ns/1ps
module sbsc_ctrl_model (
    // Clock
    input  wire logic               ref_clk_in,
    // Command pins towards the device
    output sbsc_pkg::sbsc_pins_type pins_out
);
    import sbsc_pkg::*;
    // Start deselected so the reset edges see a quiet bus
    initial pins_out = {4'hF, 10'h000};
    // Caller owns command order and spacing
    task automatic issue(input sbsc_cmd_type c, input int b,
                         input logic ap);
        logic [3:0] s;
        case (c)
            deselect_cmd:   s = 4'h8;
            nop_cmd:        s = 4'h7;
            burst_stop_cmd: s = 4'h6;
            column_read_cmd, column_read_autoprecharge_cmd: s = 4'h5;
            column_write_cmd, column_write_autoprecharge_cmd: s = 4'h4;
            activate_cmd:   s = 4'h3;
            precharge_cmd, precharge_all_cmd: s = 4'h2;
            refresh_cmd:    s = 4'h1;
            default:        s = 4'h0;
        endcase
        // Driven just after the edge, held until the next call
        @(posedge ref_clk_in);
        #1;
        pins_out = {s, b[0], ap || c inside {column_read_autoprecharge_cmd,
                    column_write_autoprecharge_cmd, precharge_all_cmd},
                    8'($urandom)};
    endtask
endmodule

// ==== verification/sbsc_top_properties.sv ====
// Concurrent checks on bank 0 of the command interpreter.
// Assumes only the top module's ports are visible; bound below.
`timescale 1ns/1ps
`include "sbsc_map.svh"
module sbsc_top_properties (
    // Clock and reset
    input wire logic                           ref_clk_in,
    input wire logic                           rst_in,
    // Watched ports
    input wire sbsc_pkg::sbsc_pins_type        pins_in,
    input wire logic [1:0]                     burst_done_in,
    input wire sbsc_pkg::sbsc_bank_status_type bank0_out,
    input wire sbsc_pkg::sbsc_bank_status_type bank1_out,
    input wire logic                           spacing_error_out
);
    import sbsc_pkg::*;
    logic [3:0]          s;
    logic                a0;
    logic                act0;
    logic                act1;
    logic                pre0;
    logic                col0;
    logic                rd0;
    sbsc_bank_state_type st0;
    // Strobe pattern, bank 0 command classes and the bank 1 activate
    assign s = {pins_in.chip_select_n, pins_in.row_strobe_n,
                pins_in.col_strobe_n, pins_in.write_enable_n};
    assign a0 = !pins_in.addr[`SBSC_BANK_SELECT_BIT];
    assign act0 = s == 4'h3 && a0;
    assign act1 = s == 4'h3 && !a0;
    assign pre0 = s == 4'h2
                  && (a0 || pins_in.addr[`SBSC_AUTO_PRECHARGE_BIT]);
    assign col0 = s[3:1] == 3'h2 && a0;
    assign rd0 = s == 4'h5 && a0;
    assign st0 = bank0_out.state;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // Timed dwell sequences
    sequence s_act;
        (st0 == bank_activating) [*6] ##1 st0 == bank_row_active;
    endsequence
    sequence s_pre;
        (st0 == bank_precharging) [*6] ##1 st0 == bank_idle;
    endsequence
    sequence s_ap_rec;
        (st0 == bank_autopre_recovery) [*2];
    endsequence
    property p_act;
        st0 == bank_idle && act0 |=> s_act;
    endproperty
    property p_pre;
        st0 == bank_row_active && pre0 |=> s_pre;
    endproperty
    property p_autopre;
        st0 == bank_write_autopre && burst_done_in[0] |=> s_ap_rec ##1 s_pre;
    endproperty
    // Column writes in recovery restart a burst and reads end it, so the wait excludes them
    property p_wrec;
        st0 == bank_writing && burst_done_in[0] ##1 !col0 ##1 !col0
            |=> st0 == bank_row_active;
    endproperty
    property p_wrec_rd;
        st0 == bank_write_recovery && rd0 |=> bank0_out.read_start;
    endproperty
    property p_pre_rpt;
        st0 == bank_precharging && pre0 |=> !bank0_out.illegal;
    endproperty
    property p_other;
        st0 == bank_precharging && act1 && bank1_out.state == bank_idle
            |=> bank1_out.state == bank_activating && !bank0_out.illegal;
    endproperty
    property p_act_ill;
        st0 == bank_activating && (act0 || pre0 || col0)
            |=> bank0_out.illegal && st0 == bank_activating;
    endproperty
    property p_desel;
        st0 == bank_row_active && s[3]
            |=> st0 == bank_row_active && !bank0_out.illegal;
    endproperty
    a_act: assert property (p_act)
        else $error("activation dwell wrong");
    a_pre: assert property (p_pre)
        else $error("precharge dwell wrong");
    a_autopre: assert property (p_autopre)
        else $error("auto precharge sequence wrong");
    a_wrec: assert property (p_wrec)
        else $error("write recovery dwell wrong");
    a_wrec_rd: assert property (p_wrec_rd)
        else $error("read in recovery not started");
    a_pre_rpt: assert property (p_pre_rpt)
        else $error("repeat precharge flagged");
    a_other: assert property (p_other)
        else $error("other bank activate mishandled");
    a_act_ill: assert property (p_act_ill)
        else $error("illegal command during activation");
    a_desel: assert property (p_desel)
        else $error("deselect had an effect");
endmodule

bind sbsc_top sbsc_top_properties i_sbsc_top_properties (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .pins_in(pins_in),
    .burst_done_in(burst_done_in), .bank0_out(bank0_out),
    .bank1_out(bank1_out), .spacing_error_out(spacing_error_out));

// ==== verification/sbsc_top_tb.sv ====
// Self-checking bench for the two-bank command interpreter.
// Assumes the controller model drives the pins; checker bound aside.
`timescale 1ns/1ps
`include "sbsc_map.svh"
module sbsc_top_tb;
    import sbsc_pkg::*;
    logic                 ref_clk_in = 1'b0;
    logic                 rst_in = 1'b1;
    logic [1:0]           bd = 2'h0;
    sbsc_pins_type        pins;
    sbsc_bank_status_type st [2];
    logic                 spacing_err;
    int                   err_total = 0;
    int                   cmp_count = 0;
    sbsc_cmd_type noise [3] = '{deselect_cmd, nop_cmd, burst_stop_cmd};
    sbsc_cmd_type ill [9] = '{column_read_cmd, column_read_autoprecharge_cmd,
        column_write_cmd, column_write_autoprecharge_cmd, activate_cmd,
        precharge_cmd, precharge_all_cmd, refresh_cmd, mode_register_set_cmd};
    // Clock
    always #2.5 ref_clk_in = ~ref_clk_in;
    // Far side and device
    sbsc_ctrl_model i_sbsc_ctrl_model (.ref_clk_in(ref_clk_in),
        .pins_out(pins));
    sbsc_top i_sbsc_top (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .pins_in(pins), .burst_done_in(bd), .bank0_out(st[0]),
        .bank1_out(st[1]), .spacing_error_out(spacing_err));
    // Cycles a transient state lasts
    function automatic int dwell(sbsc_bank_state_type s);
        case (s)
            bank_activating:  return `SBSC_ACT_TO_COL_CYC;
            bank_precharging: return `SBSC_PRECHARGE_CYC;
            default:          return `SBSC_WR_TO_PRE_CYC;
        endcase
    endfunction
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic chk_state(input int b, input sbsc_bank_state_type exp);
        cmp_count++;
        if (st[b].state !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %0h exp %0h", $time, st[b].state, exp);
        end
    endtask
    task automatic step(input sbsc_cmd_type c, input int b, input logic ap);
        i_sbsc_ctrl_model.issue(c, b, ap);
    endtask
    // Random harmless commands; state must hold for n cycles
    task automatic quiet(input int b, input sbsc_bank_state_type s,
                         input int n);
        repeat (n) begin
            step(noise[$urandom % 3], $urandom % 2, 1'($urandom));
            chk_state(b, s);
        end
    endtask
    // Reset held over exactly 8 edges; the bus goes quiet meanwhile
    task automatic do_reset();
        rst_in = 1'b1;
        bd = 2'h0;
        repeat (8) step(deselect_cmd, 0, 1'b0);
        rst_in = 1'b0;
    endtask
    task automatic ramp(input int b);
        step(activate_cmd, b, 1'b0);
        quiet(b, bank_activating, dwell(bank_activating));
        quiet(b, bank_row_active, 1);
    endtask
    // Write, last beat next cycle, first recovery cycle checked
    task automatic wburst(input int b, input logic ap);
        step(ap ? column_write_autoprecharge_cmd : column_write_cmd, b, ap);
        step(nop_cmd, b, 1'b0);
        chk_state(b, ap ? bank_write_autopre : bank_writing);
        bd[b] = 1'b1;
        step(nop_cmd, b, 1'b0);
        bd[b] = 1'b0;
        chk_state(b, ap ? bank_autopre_recovery : bank_write_recovery);
    endtask
    initial begin
        void'($urandom(32'h46F3));
        for (int b = 0; b < 2; b++) begin
            // Fresh start: the other bank is left activating below
            do_reset();
            ramp(b);
            wburst(b, 1'b0);
            quiet(b, bank_write_recovery, dwell(bank_writing) - 1);
            quiet(b, bank_row_active, 1);
            // Read then write issued in recovery
            for (int k = 0; k < 2; k++) begin
                wburst(b, 1'b0);
                step(k ? column_write_cmd : column_read_cmd, b, 1'b0);
                step(nop_cmd, b, 1'b0);
                chk_flag(k ? st[b].write_start : st[b].read_start, 1);
                if (k) chk_state(b, bank_writing);
            end
            do_reset();
            ramp(b);
            wburst(b, 1'b1);
            quiet(b, bank_autopre_recovery, dwell(bank_writing) - 1);
            quiet(b, bank_precharging, dwell(bank_precharging));
            quiet(b, bank_idle, 1);
            // Precharge, repeat it, then activates to both banks
            ramp(b);
            step(precharge_cmd, b, 1'b0);
            quiet(b, bank_precharging, 1);
            step(b ? precharge_all_cmd : precharge_cmd, b, 1'b0);
            step(activate_cmd, b, 1'b0);
            chk_flag(st[b].illegal, 1'b0);
            step(activate_cmd, 1 - b, 1'b0);
            chk_flag(st[b].illegal, 1'b1);
            step(nop_cmd, b, 1'b0);
            chk_state(1 - b, bank_activating);
            quiet(b, bank_precharging, dwell(bank_precharging) - 5);
            quiet(b, bank_idle, 1);
            $display("test bank %0d done", b);
        end
        // Every non-idle command refused while activating
        foreach (ill[i]) begin
            int b;
            // Banks alternate so bank 0 sees column, activate, precharge
            b = i % 2;
            do_reset();
            step(activate_cmd, b, 1'b0);
            step(ill[i], b, 1'b0);
            step(nop_cmd, b, 1'b0);
            chk_flag(st[b].illegal, 1'b1);
            chk_flag(st[1 - b].illegal, 1'b0);
            chk_state(b, bank_activating);
        end
        $display("test refusals done");
        // Bank-to-bank activate spacing, short and exact
        for (int g = 1; g <= `SBSC_ACT_TO_ACT_CYC; g += 3) begin
            do_reset();
            step(activate_cmd, 0, 1'b0);
            repeat (g - 1) step(nop_cmd, 0, 1'b0);
            step(activate_cmd, 1, 1'b0);
            step(nop_cmd, 0, 1'b0);
            chk_flag(spacing_err, g < `SBSC_ACT_TO_ACT_CYC);
        end
        $display("test spacing done");
        report_and_stop();
    end
endmodule

// ==== verilog/sbsc_bank.sv ====
// One bank's state and timer for the command interpreter.
// Assumes the caller has decoded the command and routed it by bank.
`timescale 1ns/1ps
`include "sbsc_map.svh"

module sbsc_bank (
    // Clock and reset
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_in,
    // Command for this bank
    input  wire sbsc_pkg::sbsc_bank_cmd_type cmd_in,
    input  wire logic                      burst_done_in,
    // Report
    output sbsc_pkg::sbsc_bank_status_type status_out
);
    import sbsc_pkg::*;

    sbsc_bank_state_type        state_q;
    sbsc_bank_state_type        state_d;
    logic [`SBSC_TIMER_W-1:0]   timer_q;
    logic [`SBSC_TIMER_W-1:0]   timer_d;
    logic                       illegal_q;
    logic                       illegal_d;
    logic                       rd_q;
    logic                       wr_q;
    logic                       timer_done;
    sbsc_cmd_type               c;

    assign c          = cmd_in.hit ? cmd_in.cmd : nop_cmd;
    assign timer_done = (timer_q <= `SBSC_TIMER_W'(1));

    // Next state; refused commands are flagged and otherwise ignored
    always_comb begin
        state_d   = state_q;
        timer_d   = (timer_q != '0) ? timer_q - 1'b1 : timer_q;
        illegal_d = 1'b0;
        unique case (state_q)
            bank_idle: begin
                if (c == activate_cmd) begin
                    state_d = bank_activating;
                    timer_d = `SBSC_TIMER_W'(`SBSC_ACT_TO_COL_CYC);
                end else if (c inside {column_read_cmd, column_write_cmd,
                        column_read_autoprecharge_cmd,
                        column_write_autoprecharge_cmd}) begin
                    illegal_d = 1'b1;
                end
            end
            bank_activating: begin
                // Strobes that are no-ops only wait out the delay
                if (timer_done) begin
                    state_d = bank_row_active;
                end
                if (!(c inside {deselect_cmd, nop_cmd, burst_stop_cmd})) begin
                    illegal_d = 1'b1;
                end
            end
            bank_row_active, bank_writing, bank_write_recovery: begin
                if (c == column_write_cmd) begin
                    state_d = bank_writing;
                end else if (c == column_write_autoprecharge_cmd) begin
                    state_d = bank_write_autopre;
                end else if (c inside {column_read_cmd,
                        column_read_autoprecharge_cmd}) begin
                    state_d = bank_row_active;
                end else if (c inside {precharge_cmd, precharge_all_cmd}
                        && state_q != bank_write_recovery) begin
                    state_d = bank_precharging;
                    timer_d = `SBSC_TIMER_W'(`SBSC_PRECHARGE_CYC);
                end else if (state_q == bank_writing) begin
                    if (c == burst_stop_cmd) begin
                        state_d = bank_row_active;
                    end else if (burst_done_in) begin
                        state_d = bank_write_recovery;
                        timer_d = `SBSC_TIMER_W'(`SBSC_WR_TO_PRE_CYC);
                    end
                end else if (state_q == bank_write_recovery) begin
                    if (c inside {activate_cmd, precharge_cmd,
                            precharge_all_cmd, refresh_cmd,
                            mode_register_set_cmd}) begin
                        illegal_d = 1'b1;
                    end
                    // Refused commands do not stretch the recovery time
                    if (timer_done) begin
                        state_d = bank_row_active;
                    end
                end else if (c inside {activate_cmd, refresh_cmd,
                        mode_register_set_cmd}) begin
                    illegal_d = 1'b1;
                end
            end
            bank_write_autopre: begin
                // Burst end comes from the data path; a refused command
                // beside it must not strand the bank in this state
                if (burst_done_in) begin
                    state_d = bank_autopre_recovery;
                    timer_d = `SBSC_TIMER_W'(`SBSC_WR_TO_PRE_CYC);
                end
                if (!(c inside {deselect_cmd, nop_cmd})) begin
                    illegal_d = 1'b1;
                end
            end
            bank_autopre_recovery: begin
                if (timer_done) begin
                    state_d = bank_precharging;
                    timer_d = `SBSC_TIMER_W'(`SBSC_PRECHARGE_CYC);
                end
                if (!(c inside {deselect_cmd, nop_cmd, burst_stop_cmd})) begin
                    illegal_d = 1'b1;
                end
            end
            bank_precharging: begin
                // Repeat precharge never reloads the timer
                if (timer_done) begin
                    state_d = bank_idle;
                end
                if (c inside {column_read_cmd, column_write_cmd,
                        column_read_autoprecharge_cmd,
                        column_write_autoprecharge_cmd, activate_cmd,
                        refresh_cmd, mode_register_set_cmd}) begin
                    illegal_d = 1'b1;
                end
            end
        endcase
    end

    // State and timer registers
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q   <= bank_idle;
            timer_q   <= '0;
            illegal_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            timer_q   <= timer_d;
            illegal_q <= illegal_d;
        end
    end

    // Burst start pulses, registered
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            rd_q <= !illegal_d && state_q != bank_idle
                    && c inside {column_read_cmd,
                                 column_read_autoprecharge_cmd};
            wr_q <= !illegal_d && state_q != bank_idle
                    && c inside {column_write_cmd,
                                 column_write_autoprecharge_cmd};
        end
    end

    assign status_out = '{state: state_q, illegal: illegal_q,
                          read_start: rd_q, write_start: wr_q};

endmodule

// ==== verilog/sbsc_map.svh ====
// Timing counts and field positions for the bank command interpreter.
// Assumes a 200 MHz device clock; times are given in picoseconds.
`ifndef SBSC_MAP_SVH
`define SBSC_MAP_SVH

`define SBSC_CLK_PERIOD_PS        5000
// Precharge-to-idle time
`define SBSC_PRECHARGE_TIME_PS    30000
// Activate-to-column delay
`define SBSC_ACT_TO_COL_PS        30000
// Write-data-to-precharge time
`define SBSC_WR_TO_PRE_PS         10000
// Bank-to-bank activate spacing
`define SBSC_ACT_TO_ACT_PS        20000
// Least times round up to whole cycles
`define SBSC_CYC(ps) \
    (((ps) + `SBSC_CLK_PERIOD_PS - 1) / `SBSC_CLK_PERIOD_PS)
`define SBSC_PRECHARGE_CYC        `SBSC_CYC(`SBSC_PRECHARGE_TIME_PS)
`define SBSC_ACT_TO_COL_CYC       `SBSC_CYC(`SBSC_ACT_TO_COL_PS)
`define SBSC_WR_TO_PRE_CYC        `SBSC_CYC(`SBSC_WR_TO_PRE_PS)
`define SBSC_ACT_TO_ACT_CYC       `SBSC_CYC(`SBSC_ACT_TO_ACT_PS)
// Width of each bank's timer
`define SBSC_TIMER_W              4
// Address layout
`define SBSC_ADDR_W               10
`define SBSC_BANK_SELECT_BIT      9
`define SBSC_AUTO_PRECHARGE_BIT   8
// Reset state
`define SBSC_BURST_LEN_RESET      4'h4

`endif

// ==== verilog/sbsc_pkg.sv ====
// Types shared by the bank command interpreter and its bank tracker.
// Assumes the map header is on the include path.
`include "sbsc_map.svh"

package sbsc_pkg;

    // Decoded command set
    typedef enum logic [3:0] {
        deselect_cmd,
        nop_cmd,
        burst_stop_cmd,
        column_read_cmd,
        column_read_autoprecharge_cmd,
        column_write_cmd,
        column_write_autoprecharge_cmd,
        activate_cmd,
        precharge_cmd,
        precharge_all_cmd,
        refresh_cmd,
        mode_register_set_cmd
    } sbsc_cmd_type;

    // Per-bank state
    typedef enum logic [2:0] {
        bank_idle,
        bank_activating,
        bank_row_active,
        bank_writing,
        bank_write_autopre,
        bank_write_recovery,
        bank_autopre_recovery,
        bank_precharging
    } sbsc_bank_state_type;

    // Raw command pins, active low strobes
    typedef struct packed {
        logic                       chip_select_n;
        logic                       row_strobe_n;
        logic                       col_strobe_n;
        logic                       write_enable_n;
        logic [`SBSC_ADDR_W-1:0]    addr;
    } sbsc_pins_type;

    // Command routed to one bank
    typedef struct packed {
        sbsc_cmd_type cmd;
        logic         hit;
    } sbsc_bank_cmd_type;

    // Per-bank report
    typedef struct packed {
        sbsc_bank_state_type state;
        logic                illegal;
        logic                read_start;
        logic                write_start;
    } sbsc_bank_status_type;

endpackage

// ==== verilog/sbsc_top.sv ====
// Two-bank command interpreter of a synchronous DRAM.
// Assumes command pins are synchronous to ref_clk_in; no clock enable.
`timescale 1ns/1ps
`include "sbsc_map.svh"

module sbsc_top (
    // Clock and reset
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_in,
    // Command pins
    input  wire sbsc_pkg::sbsc_pins_type      pins_in,
    // Burst length counter end, per bank
    input  wire logic [1:0]                   burst_done_in,
    // Bank reports
    output sbsc_pkg::sbsc_bank_status_type    bank0_out,
    output sbsc_pkg::sbsc_bank_status_type    bank1_out,
    output logic                              spacing_error_out
);
    import sbsc_pkg::*;

    // Decode of the strobes, chip select first
    function automatic sbsc_cmd_type decode(input sbsc_pins_type p);
        logic ap;
        ap = p.addr[`SBSC_AUTO_PRECHARGE_BIT];
        if (p.chip_select_n) begin
            return deselect_cmd;
        end
        unique case ({p.row_strobe_n, p.col_strobe_n, p.write_enable_n})
            3'h7: return nop_cmd;
            3'h6: return burst_stop_cmd;
            3'h5: return ap ? column_read_autoprecharge_cmd
                            : column_read_cmd;
            3'h4: return ap ? column_write_autoprecharge_cmd
                            : column_write_cmd;
            3'h3: return activate_cmd;
            3'h2: return ap ? precharge_all_cmd : precharge_cmd;
            3'h1: return refresh_cmd;
            3'h0: return mode_register_set_cmd;
        endcase
    endfunction

    sbsc_cmd_type           cmd;
    logic                   bank_sel;
    logic                   all_banks;
    sbsc_bank_cmd_type      route [2];
    logic [`SBSC_TIMER_W-1:0] space_q;
    logic                   last_bank_q;
    logic                   spacing_error_q;

    // Pins are only looked at here, once per rising edge
    assign cmd       = decode(pins_in);
    assign bank_sel  = pins_in.addr[`SBSC_BANK_SELECT_BIT];
    // Chip-wide commands reach both banks
    assign all_banks = cmd inside {deselect_cmd, nop_cmd, burst_stop_cmd,
                                   precharge_all_cmd, refresh_cmd,
                                   mode_register_set_cmd};

    // Route bank-dependent commands by the select bit
    always_comb begin
        for (int b = 0; b < 2; b++) begin
            route[b].cmd = cmd;
            route[b].hit = all_banks || (bank_sel == 1'(b));
        end
    end

    // Bank trackers
    sbsc_bank u_bank0 (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .cmd_in        (route[0]),
        .burst_done_in (burst_done_in[0]),
        .status_out    (bank0_out)
    );

    sbsc_bank u_bank1 (
        .ref_clk_in    (ref_clk_in),
        .rst_in        (rst_in),
        .cmd_in        (route[1]),
        .burst_done_in (burst_done_in[1]),
        .status_out    (bank1_out)
    );

    // Bank-to-bank activate spacing watch; flags, does not block
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            space_q         <= '0;
            last_bank_q     <= 1'b0;
            spacing_error_q <= 1'b0;
        end else begin
            spacing_error_q <= 1'b0;
            if (space_q != '0) begin
                space_q <= space_q - 1'b1;
            end
            if (cmd == activate_cmd) begin
                space_q     <= `SBSC_TIMER_W'(`SBSC_ACT_TO_ACT_CYC - 1);
                last_bank_q <= bank_sel;
                spacing_error_q <= (space_q != '0)
                                   && (last_bank_q != bank_sel);
            end
        end
    end

    assign spacing_error_out = spacing_error_q;

endmodule
